/* File: hdl/ptc_pkg.sv */
// Constants shared by the PTP timestamp control block and its time counter.
package ptc_pkg;
  localparam int unsigned TIME_W = 32;
  localparam int unsigned ADDR_W = 8;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_UPD_SEC    = 8'h04;
  localparam logic [7:0] ADDR_UPD_SUB    = 8'h08;
  localparam logic [7:0] ADDR_ADDEND     = 8'h0C;
  localparam logic [7:0] ADDR_SUB_INC    = 8'h10;
  localparam logic [7:0] ADDR_TGT_SEC    = 8'h14;
  localparam logic [7:0] ADDR_TGT_SUB    = 8'h18;
  localparam logic [7:0] ADDR_SYS_SEC    = 8'h1C;
  localparam logic [7:0] ADDR_SYS_SUB    = 8'h20;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h24;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h28;
  localparam logic [7:0] ADDR_SNAP_SEC   = 8'h2C;
  localparam logic [7:0] ADDR_SNAP_SUB   = 8'h30;
  // Control register field positions.
  localparam int CTRL_IPV4_BIT    = 13;
  localparam int CTRL_IPV6_BIT    = 12;
  localparam int CTRL_RAW_BIT     = 11;
  localparam int CTRL_V2_BIT      = 10;
  localparam int CTRL_ROLL_BIT    = 9;
  localparam int CTRL_ALL_BIT     = 8;
  localparam int CTRL_ADDEND_BIT  = 5;
  localparam int CTRL_TARGET_BIT  = 4;
  localparam int CTRL_UPDATE_BIT  = 3;
  localparam int UPD_SUB_SIGN_BIT = 31;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_2000;
  localparam logic [31:0] CTRL_RW_MASK = 32'h0007_FF10;
  localparam logic [31:0] ZERO_RESET   = 32'h0000_0000;
  // Subsecond rollover limits.
  localparam logic [31:0] SUB_MAX_DIGITAL = 32'h3B9A_C9FF;
  localparam logic [31:0] SUB_MAX_BINARY  = 32'h7FFF_FFFF;
  // Encapsulation codes on the receive side.
  localparam logic [1:0] ENCAP_NONE     = 2'h0;
  localparam logic [1:0] ENCAP_UDP_IPV4 = 2'h1;
  localparam logic [1:0] ENCAP_UDP_IPV6 = 2'h2;
  localparam logic [1:0] ENCAP_RAW_ETH  = 2'h3;
  localparam logic [3:0] PTP_VERSION_1  = 4'h1;
  localparam logic [3:0] PTP_VERSION_2  = 4'h2;
  // Interrupt status bits.
  localparam int STAT_TARGET_BIT = 0;
  localparam int STAT_SNAP_BIT   = 1;
  localparam int STAT_W          = 2;
endpackage

/* File: hdl/ptc_time_counter.sv */
// System time counter with addend accumulator, rollover and add or subtract update.
`timescale 1ns/1ns
module ptc_time_counter #(
  parameter int INC_W = 8
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Configuration.
  input  wire logic                        digital_rollover,
  input  wire logic [INC_W-1:0]            inc_value,
  input  wire logic                        addend_load,
  input  wire logic [ptc_pkg::TIME_W-1:0]  addend_value,
  // Time update.
  input  wire logic                        time_update,
  input  wire logic                        update_subtract,
  input  wire logic [ptc_pkg::TIME_W-1:0]  update_sec,
  input  wire logic [ptc_pkg::TIME_W-1:0]  update_sub,
  // Running time.
  output logic      [ptc_pkg::TIME_W-1:0]  sec_out,
  output logic      [ptc_pkg::TIME_W-1:0]  sub_out
);
  import ptc_pkg::*;

  initial begin
    if (INC_W < 1 || INC_W > 32) begin
      $error("INC_W must lie between 1 and 32");
    end
  end

  logic [31:0] addend_q;
  logic [31:0] acc_q;
  logic [31:0] sec_q;
  logic [31:0] sec_d;
  logic [31:0] sub_q;
  logic [31:0] sub_d;

  // Adds within the subsecond range and reports the carry into seconds.
  function automatic logic [32:0] sub_step_up(input logic [31:0] a, input logic [31:0] b,
                                              input logic [31:0] lim);
    logic [32:0] s;
    logic [32:0] r;
    s = {1'b0, a} + {1'b0, b};
    r = s - {1'b0, lim} - 33'h1;
    if (s > {1'b0, lim}) begin
      return {1'b1, r[31:0]};
    end
    return {1'b0, s[31:0]};
  endfunction

  wire [31:0] max_sub   = digital_rollover ? SUB_MAX_DIGITAL : SUB_MAX_BINARY;
  wire [32:0] acc_sum   = {1'b0, acc_q} + {1'b0, addend_q};
  wire        tick      = acc_sum[32];
  wire [31:0] inc_ext   = 32'(inc_value);
  wire [32:0] tick_step = sub_step_up(sub_q, inc_ext, max_sub);
  wire [32:0] upd_up    = sub_step_up(sub_q, update_sub, max_sub);
  wire        borrow    = sub_q < update_sub;
  wire [32:0] dn_raw    = {1'b0, sub_q} + {1'b0, max_sub} + 33'h1 - {1'b0, update_sub};
  wire [31:0] upd_dn    = borrow ? dn_raw[31:0] : sub_q - update_sub;
  // A switch from binary to digital rollover can leave the count above the new limit.
  wire        stale     = sub_q > max_sub;

  always_comb begin
    sec_d = sec_q;
    sub_d = sub_q;
    if (time_update) begin
      if (update_subtract) begin
        sub_d = upd_dn;
        sec_d = sec_q - update_sec - 32'(borrow);
      end else begin
        sub_d = upd_up[31:0];
        sec_d = sec_q + update_sec + 32'(upd_up[32]);
      end
    end else if (stale) begin
      sub_d = ZERO_RESET;
      sec_d = sec_q + 32'h0000_0001;
    end else if (tick) begin
      sub_d = tick_step[31:0];
      sec_d = sec_q + 32'(tick_step[32]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addend_q <= ZERO_RESET;
      acc_q    <= ZERO_RESET;
      sec_q    <= ZERO_RESET;
      sub_q    <= ZERO_RESET;
    end else begin
      acc_q <= acc_sum[31:0];
      sec_q <= sec_d;
      sub_q <= sub_d;
      if (addend_load) begin
        addend_q <= addend_value;
      end
    end
  end

  assign sec_out = sec_q;
  assign sub_out = sub_q;

  chk_digital_wrap_carry: assert property (@(posedge clk) disable iff (rst)
    digital_rollover && tick && !time_update && !stale && inc_ext != 32'h0000_0000 &&
    sub_q == SUB_MAX_DIGITAL |=> sec_q == $past(sec_q) + 32'h0000_0001 &&
    sub_q < $past(inc_ext))
    else $error("digital rollover did not wrap into seconds");

  chk_binary_wrap_carry: assert property (@(posedge clk) disable iff (rst)
    !digital_rollover && tick && !time_update && inc_ext != 32'h0000_0000 &&
    sub_q == SUB_MAX_BINARY |=> sec_q == $past(sec_q) + 32'h0000_0001 &&
    sub_q < $past(inc_ext))
    else $error("binary rollover did not wrap into seconds");

  chk_addend_used: assert property (@(posedge clk) disable iff (rst)
    addend_load ##1 !addend_load |-> ##1 acc_q == $past(acc_q) + $past(addend_value, 2))
    else $error("loaded addend not used by the accumulator");
endmodule // ptc_time_counter

/* File: hdl/ptc_timestamp_control.sv */
// PTP timestamp control register block with APB slave, frame filter and interrupts.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
// Function
// - UDP over IPv4 processing enable, resets set
// - UDP over IPv6 enable, bit 12, resets clear
// - Raw Ethernet PTP enable, bit 11
// - Bit 10 picks version two parsing
// - Digital rollover wraps after 0x3B9A_C9FF, carries seconds
// - Binary rollover wraps after 0x7FFF_FFFF, carries seconds
// - Bit 8 snapshots every received frame
// - Addend trigger loads addend, then self-clears
// - Target interrupt on time passing target, clears enable
// - Time trigger adds or subtracts update, self-clears
module ptc_timestamp_control #(
  parameter int INC_W = 8
) (
  // Clock and reset.
  input  wire logic                         CLOCK,
  input  wire logic                         SYS_RST,
  // APB slave.
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [ptc_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [31:0]                  PWDATA,
  output logic      [31:0]                  PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  // Receive path frame report.
  input  wire logic                         RX_FRAME_VALID,
  input  wire logic [1:0]                   RX_ENCAP,
  input  wire logic [3:0]                   RX_PTP_VERSION,
  // Configuration toward the receive path.
  output logic                              PTP_UDP_IPV4_ENABLE,
  output logic                              PTP_UDP_IPV6_ENABLE,
  output logic                              PTP_RAW_ETHERNET_ENABLE,
  output logic                              PTP_VERSION_TWO_SELECT,
  // Snapshot result.
  output logic                              SNAP_VALID,
  output logic      [ptc_pkg::TIME_W-1:0]   SNAP_SEC,
  output logic      [ptc_pkg::TIME_W-1:0]   SNAP_SUBSEC,
  // System time.
  output logic      [ptc_pkg::TIME_W-1:0]   SYS_TIME_SEC,
  output logic      [ptc_pkg::TIME_W-1:0]   SYS_TIME_SUBSEC,
  // Interrupt.
  output logic                              IRQ
);
  import ptc_pkg::*;

  initial begin
    if (INC_W < 1 || INC_W > 32) begin
      $error("INC_W must lie between 1 and 32");
    end
  end

  logic [31:0]       ctrl_q;
  logic [31:0]       ctrl_d;
  logic [31:0]       upd_sec_q;
  logic [31:0]       upd_sub_q;
  logic [31:0]       addend_q;
  logic [INC_W-1:0]  inc_q;
  logic [31:0]       tgt_sec_q;
  logic [31:0]       tgt_sub_q;
  logic [STAT_W-1:0] status_q;
  logic [STAT_W-1:0] status_d;
  logic [STAT_W-1:0] mask_q;
  logic [31:0]       prdata_q;
  logic              snap_valid_q;
  logic [31:0]       snap_sec_q;
  logic [31:0]       snap_sub_q;
  logic [31:0]       sys_sec;
  logic [31:0]       sys_sub;
  logic [31:0]       rd_value;

  // Bus decode. The slave never waits, so the access phase always completes.
  wire setup_rd = PSEL && !PENABLE && !PWRITE;
  wire access   = PSEL && PENABLE;
  wire wr_en    = access && PWRITE;
  wire sel_ctrl = PADDR == ADDR_CTRL;
  wire sel_usec = PADDR == ADDR_UPD_SEC;
  wire sel_usub = PADDR == ADDR_UPD_SUB;
  wire sel_add  = PADDR == ADDR_ADDEND;
  wire sel_inc  = PADDR == ADDR_SUB_INC;
  wire sel_tsec = PADDR == ADDR_TGT_SEC;
  wire sel_tsub = PADDR == ADDR_TGT_SUB;
  wire sel_ssec = PADDR == ADDR_SYS_SEC;
  wire sel_ssub = PADDR == ADDR_SYS_SUB;
  wire sel_stat = PADDR == ADDR_INT_STATUS;
  wire sel_mask = PADDR == ADDR_INT_MASK;
  wire sel_psec = PADDR == ADDR_SNAP_SEC;
  wire sel_psub = PADDR == ADDR_SNAP_SUB;
  wire addr_hit = sel_ctrl | sel_usec | sel_usub | sel_add | sel_inc | sel_tsec |
                  sel_tsub | sel_ssec | sel_ssub | sel_stat | sel_mask | sel_psec |
                  sel_psub;
  wire wr_ctrl  = wr_en && sel_ctrl;
  wire wr_stat  = wr_en && sel_stat;

  // Control fields.
  wire ipv4_en    = ctrl_q[CTRL_IPV4_BIT];
  wire ipv6_en    = ctrl_q[CTRL_IPV6_BIT];
  wire raw_en     = ctrl_q[CTRL_RAW_BIT];
  wire ver_two    = ctrl_q[CTRL_V2_BIT];
  wire digital    = ctrl_q[CTRL_ROLL_BIT];
  wire snap_all   = ctrl_q[CTRL_ALL_BIT];
  wire addend_trg = ctrl_q[CTRL_ADDEND_BIT];
  wire target_en  = ctrl_q[CTRL_TARGET_BIT];
  wire update_trg = ctrl_q[CTRL_UPDATE_BIT];

  // Receive classification.
  wire enc_v4      = RX_ENCAP == ENCAP_UDP_IPV4;
  wire enc_v6      = RX_ENCAP == ENCAP_UDP_IPV6;
  wire enc_raw     = RX_ENCAP == ENCAP_RAW_ETH;
  wire enc_enabled = (enc_v4 && ipv4_en) ||
                     (enc_v6 && ipv6_en) ||
                     (enc_raw && raw_en);
  wire ver_match   = ver_two ? RX_PTP_VERSION == PTP_VERSION_2 :
                               RX_PTP_VERSION == PTP_VERSION_1;
  wire rx_is_ptp   = enc_enabled && ver_match;
  wire rx_take     = RX_FRAME_VALID && (rx_is_ptp || snap_all);

  // Target comparison is strict: equal time does not fire.
  wire time_gt     = sys_sec > tgt_sec_q || (sys_sec == tgt_sec_q && sys_sub > tgt_sub_q);
  wire target_fire = target_en && time_gt;

  // A trigger bit stays set for exactly the cycle in which the counter consumes it.
  always_comb begin
    ctrl_d = ctrl_q;
    if (addend_trg) begin
      ctrl_d[CTRL_ADDEND_BIT] = 1'b0;
    end
    if (update_trg) begin
      ctrl_d[CTRL_UPDATE_BIT] = 1'b0;
    end
    if (target_fire) begin
      ctrl_d[CTRL_TARGET_BIT] = 1'b0;
    end
    if (wr_ctrl) begin
      ctrl_d = (ctrl_d & ~CTRL_RW_MASK) | (PWDATA & CTRL_RW_MASK);
      if (PWDATA[CTRL_ADDEND_BIT]) begin
        ctrl_d[CTRL_ADDEND_BIT] = 1'b1;
      end
      if (PWDATA[CTRL_UPDATE_BIT]) begin
        ctrl_d[CTRL_UPDATE_BIT] = 1'b1;
      end
    end
  end

  // Hardware events win over a write-one clear in the same cycle.
  always_comb begin
    status_d = status_q;
    if (wr_stat) begin
      status_d = status_q & ~PWDATA[STAT_W-1:0];
    end
    if (target_fire) begin
      status_d[STAT_TARGET_BIT] = 1'b1;
    end
    if (rx_take) begin
      status_d[STAT_SNAP_BIT] = 1'b1;
    end
  end

  always_comb begin
    rd_value = ZERO_RESET;
    unique case (1'b1)
      sel_ctrl: rd_value = ctrl_q;
      sel_usec: rd_value = upd_sec_q;
      sel_usub: rd_value = upd_sub_q;
      sel_add:  rd_value = addend_q;
      sel_inc:  rd_value = 32'(inc_q);
      sel_tsec: rd_value = tgt_sec_q;
      sel_tsub: rd_value = tgt_sub_q;
      sel_ssec: rd_value = sys_sec;
      sel_ssub: rd_value = sys_sub;
      sel_stat: rd_value = 32'(status_q);
      sel_mask: rd_value = 32'(mask_q);
      sel_psec: rd_value = snap_sec_q;
      sel_psub: rd_value = snap_sub_q;
      default:  rd_value = ZERO_RESET;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ctrl_q   <= CTRL_RESET;
      status_q <= '0;
      prdata_q <= ZERO_RESET;
    end else begin
      ctrl_q   <= ctrl_d;
      status_q <= status_d;
      if (setup_rd) begin
        prdata_q <= rd_value;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      upd_sec_q <= ZERO_RESET;
      upd_sub_q <= ZERO_RESET;
      addend_q  <= ZERO_RESET;
      inc_q     <= '0;
      tgt_sec_q <= ZERO_RESET;
      tgt_sub_q <= ZERO_RESET;
      mask_q    <= '0;
    end else if (wr_en) begin
      if (sel_usec) begin
        upd_sec_q <= PWDATA;
      end
      if (sel_usub) begin
        upd_sub_q <= PWDATA;
      end
      if (sel_add) begin
        addend_q <= PWDATA;
      end
      if (sel_inc) begin
        inc_q <= PWDATA[INC_W-1:0];
      end
      if (sel_tsec) begin
        tgt_sec_q <= PWDATA;
      end
      if (sel_tsub) begin
        tgt_sub_q <= PWDATA;
      end
      if (sel_mask) begin
        mask_q <= PWDATA[STAT_W-1:0];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      snap_valid_q <= 1'b0;
      snap_sec_q   <= ZERO_RESET;
      snap_sub_q   <= ZERO_RESET;
    end else begin
      snap_valid_q <= rx_take;
      if (rx_take) begin
        snap_sec_q <= sys_sec;
        snap_sub_q <= sys_sub;
      end
    end
  end

  ptc_time_counter #(
    .INC_W(INC_W)
  ) ptc_time_counter_inst (
    .clk             (CLOCK),
    .rst             (SYS_RST),
    .digital_rollover(digital),
    .inc_value       (inc_q),
    .addend_load     (addend_trg),
    .addend_value    (addend_q),
    .time_update     (update_trg),
    .update_subtract (upd_sub_q[UPD_SUB_SIGN_BIT]),
    .update_sec      (upd_sec_q),
    .update_sub      ({1'b0, upd_sub_q[30:0]}),
    .sec_out         (sys_sec),
    .sub_out         (sys_sub)
  );

  assign PRDATA                  = prdata_q;
  assign PREADY                  = 1'b1;
  assign PSLVERR                 = access && !addr_hit;
  assign PTP_UDP_IPV4_ENABLE     = ipv4_en;
  assign PTP_UDP_IPV6_ENABLE     = ipv6_en;
  assign PTP_RAW_ETHERNET_ENABLE = raw_en;
  assign PTP_VERSION_TWO_SELECT  = ver_two;
  assign SNAP_VALID              = snap_valid_q;
  assign SNAP_SEC                = snap_sec_q;
  assign SNAP_SUBSEC             = snap_sub_q;
  assign SYS_TIME_SEC            = sys_sec;
  assign SYS_TIME_SUBSEC         = sys_sub;
  assign IRQ                     = |(status_q & mask_q);

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  chk_ipv4_reset_set: assert property (
    $past(SYS_RST) |-> PTP_UDP_IPV4_ENABLE && !PTP_UDP_IPV6_ENABLE)
    else $error("IPv4 enable not set after reset");

  chk_ipv4_gate_off: assert property (
    RX_FRAME_VALID && enc_v4 && !ipv4_en && !snap_all |=> !SNAP_VALID)
    else $error("IPv4 frame snapshotted while disabled");

  chk_ipv6_gate: assert property (
    RX_FRAME_VALID && enc_v6 && ver_match && !snap_all |=> SNAP_VALID == $past(ipv6_en))
    else $error("IPv6 snapshot does not follow its enable");

  chk_raw_take_time: assert property (
    RX_FRAME_VALID && enc_raw && raw_en && ver_match |=>
    SNAP_VALID && SNAP_SEC == $past(sys_sec) && SNAP_SUBSEC == $past(sys_sub))
    else $error("raw Ethernet PTP frame not snapshotted with current time");

  chk_version_mismatch: assert property (
    RX_FRAME_VALID && !ver_match && !snap_all |=> !SNAP_VALID)
    else $error("wrong PTP version snapshotted");

  chk_all_frames: assert property (
    RX_FRAME_VALID && snap_all |=> SNAP_VALID && status_q[STAT_SNAP_BIT])
    else $error("snapshot-all frame missed");

  chk_none_encap: assert property (
    RX_FRAME_VALID && RX_ENCAP == ENCAP_NONE && !snap_all |=> !SNAP_VALID)
    else $error("non-PTP frame snapshotted");

  chk_addend_self_clear: assert property (
    wr_ctrl && PWDATA[CTRL_ADDEND_BIT] |=> addend_trg ##1 !addend_trg || $past(wr_ctrl))
    else $error("addend trigger did not clear after one cycle");

  chk_target_fire: assert property (
    target_en && time_gt && !wr_ctrl |=> !target_en && status_q[STAT_TARGET_BIT])
    else $error("target interrupt did not fire or enable not cleared");

  chk_update_clear: assert property (
    update_trg && !wr_ctrl |=> !update_trg)
    else $error("time update trigger did not clear");

  chk_irq_level: assert property (
    status_q[STAT_TARGET_BIT] && mask_q[STAT_TARGET_BIT] |-> IRQ)
    else $error("unmasked status did not raise interrupt");

  cov_snapshot: cover property (RX_FRAME_VALID && rx_is_ptp ##1 SNAP_VALID);
  cov_target_irq: cover property (target_fire ##1 IRQ);
  cov_addend_update: cover property (addend_trg ##1 !addend_trg);
  cov_time_subtract: cover property (update_trg && upd_sub_q[UPD_SUB_SIGN_BIT]);
endmodule // ptc_timestamp_control

/* File: testbench/ptc_rx_model.sv */
// Behavioural model of the MAC receive path that reports received frames.
`timescale 1ns/1ns
module ptc_rx_model (
  // Clock.
  input  wire logic        clk,
  // Frame report.
  output logic             frame_valid,
  output logic [1:0]       encap,
  output logic [3:0]       version
);
  initial begin
    frame_valid = 1'b0;
    encap       = 2'h0;
    version     = 4'h0;
  end

  // Fields are inverted after a report so a stale value is never mistaken for data.
  task automatic send(input logic [1:0] e, input logic [3:0] v);
    @(posedge clk);
    frame_valid <= 1'b1;
    encap       <= e;
    version     <= v;
    @(posedge clk);
    frame_valid <= 1'b0;
    encap       <= ~e;
    version     <= ~v;
  endtask
endmodule // ptc_rx_model

/* File: testbench/ptc_timestamp_control_tb.sv */
// Self-checking testbench for the PTP timestamp control block.
`timescale 1ns/1ns
module ptc_timestamp_control_tb;
  import ptc_pkg::*;
  logic        clock;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frame_valid;
  logic [1:0]  encap;
  logic [3:0]  version;
  logic        ipv4_en;
  logic        ipv6_en;
  logic        raw_en;
  logic        v2_sel;
  logic        snap_valid;
  logic [31:0] snap_sec;
  logic [31:0] snap_sub;
  logic [31:0] sys_sec;
  logic [31:0] sys_sub;
  logic        irq;
  logic [31:0] rdata;
  logic        serr;
  logic [31:0] ctrl;
  int          errors;
  int          checked;
  int          cycles;

  ptc_timestamp_control #(.INC_W(8)) ptc_timestamp_control_inst (
    .CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_FRAME_VALID(frame_valid), .RX_ENCAP(encap), .RX_PTP_VERSION(version),
    .PTP_UDP_IPV4_ENABLE(ipv4_en), .PTP_UDP_IPV6_ENABLE(ipv6_en),
    .PTP_RAW_ETHERNET_ENABLE(raw_en), .PTP_VERSION_TWO_SELECT(v2_sel),
    .SNAP_VALID(snap_valid), .SNAP_SEC(snap_sec), .SNAP_SUBSEC(snap_sub),
    .SYS_TIME_SEC(sys_sec), .SYS_TIME_SUBSEC(sys_sub), .IRQ(irq));

  ptc_rx_model ptc_rx_model_inst (
    .clk(clock), .frame_valid(frame_valid), .encap(encap), .version(version));

  always #10 clock = ~clock;

  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; data and error are taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdata = prdata;
    serr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(name, rdata, exp);
  endtask

  // Software polls a trigger bit until the hardware has dropped it.
  task automatic poll(input int pos);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_CTRL, 32'h0);
      n++;
    end while (rdata[pos] !== 1'b0 && n < 10);
    check("trigger_clear", {31'h0, rdata[pos]}, 32'h0);
  endtask

  task automatic set_time(input logic [31:0] base, input logic [31:0] sec,
                          input logic [31:0] sub);
    wr(ADDR_UPD_SEC, sec);
    wr(ADDR_UPD_SUB, sub);
    wr(ADDR_CTRL, base | 32'h0000_0008);
    poll(CTRL_UPDATE_BIT);
  endtask

  task automatic frame(input logic [1:0] e, input logic [3:0] v, input logic exp);
    ptc_rx_model_inst.send(e, v);
    #1;
    check("snap_valid", {31'h0, snap_valid}, {31'h0, exp});
    if (exp) begin
      check("snap_sec", snap_sec, 32'h0000_0004);
      check("snap_sub", snap_sub, 32'h0000_00F0);
    end
  endtask

  // Run the counter on from the start value, across the rollover limit when start sits at it, then freeze it with a zero addend.
  // The update adds to the running time, so the frozen time is subtracted away first.
  task automatic wrap_run(input logic roll, input logic [31:0] start, input logic [31:0] sec);
    logic [31:0] base;
    logic [31:0] now_sec;
    base = 32'h0000_2000 | (32'(roll) << 9);
    wr(ADDR_SUB_INC, 32'h0000_0010);
    apb(1'b0, ADDR_SYS_SEC, 32'h0);
    now_sec = rdata;
    apb(1'b0, ADDR_SYS_SUB, 32'h0);
    set_time(base, now_sec, rdata | 32'h8000_0000);
    set_time(base, 32'h0000_000A, start);
    wr(ADDR_ADDEND, 32'hFFFF_FFFF);
    wr(ADDR_CTRL, base | 32'h0000_0020);
    poll(CTRL_ADDEND_BIT);
    wr(ADDR_ADDEND, 32'h0000_0000);
    wr(ADDR_CTRL, base | 32'h0000_0020);
    poll(CTRL_ADDEND_BIT);
    rd_chk("wrap_sec", ADDR_SYS_SEC, sec);
    apb(1'b0, ADDR_SYS_SUB, 32'h0);
    check("wrap_sub_units", {28'h0, rdata[3:0]}, 32'h0000_000F);
  endtask

  initial begin
    clock   = 1'b0;
    sys_rst = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    errors  = 0;
    checked = 0;
    cycles  = 0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk("ctrl_reset", ADDR_CTRL, CTRL_RESET);
    check("ipv4_pin", {31'h0, ipv4_en}, 32'h1);
    set_time(32'h0000_2000, 32'h0000_0005, 32'h0000_0100);
    rd_chk("upd_sec", ADDR_SYS_SEC, 32'h0000_0005);
    rd_chk("upd_sub", ADDR_SYS_SUB, 32'h0000_0100);
    set_time(32'h0000_2000, 32'h0000_0001, 32'h8000_0010);
    rd_chk("sub_sec", ADDR_SYS_SEC, 32'h0000_0004);
    rd_chk("sub_sub", ADDR_SYS_SUB, 32'h0000_00F0);
    for (int e = 1; e < 4; e++) begin
      for (int v = 0; v < 2; v++) begin
        ctrl = (32'h1 << (14 - e)) | (32'(v) << 10);
        wr(ADDR_CTRL, ctrl);
        #1;
        check("enable_pins", {28'h0, ipv4_en, ipv6_en, raw_en, v2_sel},
              {28'h0, ctrl[13:10]});
        for (int f = 0; f < 4; f++) begin
          frame(2'(f), v ? 4'h2 : 4'h1, f == e);
          frame(2'(f), v ? 4'h1 : 4'h2, 1'b0);
        end
      end
    end
    wr(ADDR_CTRL, 32'h0000_0100);
    frame(2'h0, 4'h1, 1'b1);
    frame(2'h2, 4'h2, 1'b1);
    rd_chk("status_snap", ADDR_INT_STATUS, 32'h0000_0002);
    wr(ADDR_INT_STATUS, 32'h0000_0003);
    rd_chk("status_clear", ADDR_INT_STATUS, 32'h0000_0000);
    wrap_run(1'b1, 32'h3B9A_C9FF, 32'h0000_000B);
    wrap_run(1'b0, 32'h3B9A_C9FF, 32'h0000_000A);
    wrap_run(1'b0, 32'h7FFF_FFFF, 32'h0000_000B);
    check("sys_sec_pin", sys_sec, 32'h0000_000B);
    check("sys_sub_pin", {28'h0, sys_sub[3:0]}, 32'h0000_000F);
    wr(ADDR_INT_MASK, 32'h0000_0001);
    wr(ADDR_TGT_SEC, 32'h0000_000B);
    wr(ADDR_TGT_SUB, 32'hFFFF_FFFF);
    wr(ADDR_CTRL, 32'h0000_2010);
    rd_chk("target_wait", ADDR_CTRL, 32'h0000_2010);
    check("irq_idle", {31'h0, irq}, 32'h0);
    wr(ADDR_TGT_SEC, 32'h0000_000A);
    rd_chk("target_fired", ADDR_CTRL, 32'h0000_2000);
    rd_chk("status_target", ADDR_INT_STATUS, 32'h0000_0001);
    check("irq_on", {31'h0, irq}, 32'h1);
    wr(ADDR_INT_MASK, 32'h0000_0000);
    #1 check("irq_masked", {31'h0, irq}, 32'h0);
    wr(ADDR_INT_MASK, 32'h0000_0001);
    #1 check("irq_unmasked", {31'h0, irq}, 32'h1);
    wr(ADDR_INT_STATUS, 32'h0000_0001);
    #1 check("irq_cleared", {31'h0, irq}, 32'h0);
    wr(8'h40, 32'h1234_5678);
    check("err_write", {31'h0, serr}, 32'h1);
    rd_chk("unmapped_read", 8'h40, 32'h0000_0000);
    check("err_read", {31'h0, serr}, 32'h1);
    wr(ADDR_SYS_SEC, 32'h0000_1234);
    rd_chk("ro_sec", ADDR_SYS_SEC, 32'h0000_000B);
    wrap_up();
  end
endmodule // ptc_timestamp_control_tb
